// *** rtl/fes_top.sv ***
// Flash command sequencer: error flags, status and mode checks.
// Assumes APB master on mclk; mode pins and flash inputs synchronous.
`timescale 1ns/100ps
module fes_top
  import fes_pkg::*;
#(
  parameter int NBLK_USER = 8,   // User ROM blocks of 4 Kbyte
  parameter int OP_CYCLES = 16,  // Auto operation length in cycles
  parameter int CHECK_DIV = 8    // Half period of check signal
)(
  input  wire logic        mclk,            // System clock, 20 MHz
  input  wire logic        rstn,            // Async reset, active low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB write
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error, unmapped
  input  wire logic [15:0] flash_rdata,     // Array read data
  input  wire logic        verify_fail,     // Verify result at op end
  input  wire logic [31:0] flash_id,        // Identification in flash
  input  wire logic        boot_mode_pin,   // Boot mode strap
  input  wire logic        mode_select_pin, // Mode select strap
  output logic             handshake_pin,   // Busy or check signal
  output logic             handshake_pin_en // Handshake drive enable
);
  localparam int UBW = $clog2(NBLK_USER);
  localparam int BW  = UBW + 1;
  localparam int CW  = $clog2(OP_CYCLES + 1);
  localparam int DW  = $clog2(CHECK_DIV + 1);
  localparam logic [BW-1:0] BOOT_BLK = BW'(NBLK_USER);

  if (NBLK_USER < 2 || (1 << UBW) != NBLK_USER ||
      NBLK_USER * 4096 > 32'h000FF000) begin : g_chk_blk
    $error("NBLK_USER must be a power of two below boot ROM");
  end
  if (OP_CYCLES < 1 || OP_CYCLES > 4096 || CHECK_DIV < 1) begin : g_chk_cnt
    $error("OP_CYCLES or CHECK_DIV out of range");
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  fes_state_e        st_reg;
  fes_op_e           op_reg;
  logic [BW-1:0]     op_blk_reg;
  logic [CW-1:0]     cnt_reg;
  logic              ready_reg;
  logic              erase_fail_flag_reg;
  logic              program_fail_flag_reg;
  logic              lock_disable_control_reg;
  logic [19:0]       faddr_reg;
  logic [1:0]        ctrl_reg;
  logic [31:0]       idrx_reg;
  logic              lockst_reg;
  logic [DW-1:0]     chk_cnt_reg;
  logic              chk_reg;

  logic          acc_req, wr_acc, cmd_wr, first, two, known;
  logic          serial_mode, parallel_mode, id_match, cmd_ok;
  logic          boot_hit, top_ok, locked_eff, is_conf, refused;
  logic          clr, start, done, seq_err, ers_err, prg_err;
  logic [7:0]    code;
  logic [7:0]    status;
  logic [BW-1:0] cur_blk;
  logic [31:0]   rdata;
  logic          mapped;

  fes_lock_if #(.BW(BW)) lk ();

  fes_lock_table #(.NBLK(NBLK_USER + 1), .BW(BW)) u_lock (
    .mclk (mclk),
    .rstn (rstn),
    .lk   (lk)
  );

  // Access phase edge, one wait state before pready
  assign acc_req     = psel & penable & ~pready;
  assign wr_acc      = psel & penable & pready & pwrite;
  assign serial_mode   = boot_mode_pin & ~mode_select_pin;
  assign parallel_mode = boot_mode_pin & mode_select_pin;
  assign id_match      = idrx_reg == flash_id;
  assign cmd_ok = ~serial_mode | (id_match & ~ctrl_reg[CT_PROTECT]);
  // Commands written while busy are dropped, not queued
  assign cmd_wr = wr_acc & (paddr == OFS_FCMD) & cmd_ok &
                  (st_reg != ST_BUSY);
  assign code   = pwdata[7:0];
  assign first  = (st_reg == ST_ARRAY) | (st_reg == ST_STAT);
  assign two    = st_reg inside {ST_ERS2, ST_LCK2, ST_RLK2};
  assign known  = code inside {CMD_READ_ARRAY, CMD_READ_STATUS,
                  CMD_CLEAR, CMD_PROGRAM, CMD_ERASE, CMD_LOCK,
                  CMD_READ_LOCK};

  assign boot_hit = parallel_mode & (faddr_reg >= BOOT_LO) &
                    (faddr_reg <= BOOT_HI);
  assign cur_blk  = boot_hit ? BOOT_BLK
                             : {1'b0, faddr_reg[BLK_SHIFT +: UBW]};
  assign top_ok   = faddr_reg[BLK_SHIFT-1:0] == BLK_TOP;
  assign is_conf  = (code == CMD_CONFIRM) & top_ok;
  assign locked_eff = lk.locked & ~lock_disable_control_reg;
  assign refused = (erase_fail_flag_reg | program_fail_flag_reg) &
                   (code inside {CMD_PROGRAM, CMD_ERASE, CMD_LOCK});
  assign clr  = cmd_wr & first & (code == CMD_CLEAR);
  assign done = (st_reg == ST_BUSY) & (cnt_reg == '0);
  assign start = cmd_wr & (((st_reg == ST_PGM2) & ~locked_eff) |
                 ((st_reg == ST_ERS2) & is_conf & ~locked_eff) |
                 ((st_reg == ST_LCK2) & is_conf));

  assign seq_err = cmd_wr & ((first & ~known) |
                   (two & ~is_conf & (code != CMD_READ_ARRAY)));
  assign ers_err = (cmd_wr & (st_reg == ST_ERS2) & is_conf & locked_eff) |
                   (done & (op_reg == OP_ERS) & verify_fail);
  assign prg_err = (cmd_wr & (st_reg == ST_PGM2) & locked_eff) |
                   (done & (op_reg != OP_ERS) & verify_fail);

  assign lk.blk        = (st_reg == ST_BUSY) ? op_blk_reg : cur_blk;
  assign lk.set_unlock = done & (op_reg == OP_ERS) & ~verify_fail;
  assign lk.set_lock   = done & (op_reg == OP_LCK) & ~verify_fail;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_ARRAY;
    end else if (done) begin
      st_reg <= ST_STAT;
    end else if (cmd_wr) begin
      unique case (st_reg)
        ST_ARRAY, ST_STAT: begin
          if (code == CMD_READ_ARRAY) begin
            st_reg <= ST_ARRAY;
          end else if (code == CMD_READ_STATUS || !known) begin
            st_reg <= ST_STAT;
          end else if (refused) begin
            st_reg <= st_reg;
          end else if (code == CMD_PROGRAM) begin
            st_reg <= ST_PGM2;
          end else if (code == CMD_ERASE) begin
            st_reg <= ST_ERS2;
          end else if (code == CMD_LOCK) begin
            st_reg <= ST_LCK2;
          end else if (code == CMD_READ_LOCK) begin
            st_reg <= ST_RLK2;
          end
        end
        ST_PGM2: begin
          st_reg <= start ? ST_BUSY : ST_STAT;
        end
        ST_ERS2, ST_LCK2, ST_RLK2: begin
          if (code == CMD_READ_ARRAY) begin
            st_reg <= ST_ARRAY;
          end else if (start) begin
            st_reg <= ST_BUSY;
          end else begin
            st_reg <= ST_STAT;
          end
        end
        ST_BUSY: begin
          st_reg <= ST_BUSY;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      op_reg     <= OP_PGM;
      op_blk_reg <= '0;
    end else if (start) begin
      op_blk_reg <= cur_blk;
      if (st_reg == ST_PGM2) begin
        op_reg <= OP_PGM;
      end else if (st_reg == ST_ERS2) begin
        op_reg <= OP_ERS;
      end else begin
        op_reg <= OP_LCK;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg   <= '0;
      ready_reg <= READY_RST;
    end else if (start) begin
      cnt_reg   <= CW'(OP_CYCLES - 1);
      ready_reg <= 1'b0;
    end else if (done) begin
      ready_reg <= 1'b1;
    end else if (st_reg == ST_BUSY) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      erase_fail_flag_reg   <= FLAG_RST;
      program_fail_flag_reg <= FLAG_RST;
    end else begin
      erase_fail_flag_reg <= (erase_fail_flag_reg & ~clr) |
                             seq_err | ers_err;
      program_fail_flag_reg <= (program_fail_flag_reg & ~clr) |
                               seq_err | prg_err;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lockst_reg <= LOCK_RST;
    end else if (cmd_wr && st_reg == ST_RLK2 && is_conf) begin
      lockst_reg <= ~lk.locked;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faddr_reg                <= '0;
      lock_disable_control_reg <= 1'b0;
      ctrl_reg                 <= '0;
      idrx_reg                 <= '0;
    end else if (wr_acc) begin
      if (paddr == OFS_FADDR) begin
        faddr_reg <= pwdata[19:0];
      end
      if (paddr == OFS_MODE0) begin
        lock_disable_control_reg <= pwdata[M0_LOCKDIS];
      end
      if (paddr == OFS_CTRL) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == OFS_IDRX) begin
        idrx_reg <= pwdata;
      end
    end
  end

  always_comb begin
    status           = '0;
    status[SR_READY] = ready_reg;
    status[SR_ERASE] = erase_fail_flag_reg;
    status[SR_PROG]  = program_fail_flag_reg;
  end

  always_comb begin
    rdata  = '0;
    mapped = 1'b1;
    unique case (paddr)
      OFS_FCMD: begin
        if (serial_mode && ctrl_reg[CT_PROTECT]) begin
          rdata = '0;
        end else if (st_reg == ST_STAT || st_reg == ST_BUSY) begin
          rdata[7:0] = status;
        end else begin
          rdata[15:0] = flash_rdata;
        end
      end
      OFS_FADDR:  rdata[19:0] = faddr_reg;
      OFS_MODE0: begin
        rdata[M0_READY]   = ready_reg;
        rdata[M0_LOCKDIS] = lock_disable_control_reg;
        rdata[M0_PROG]    = program_fail_flag_reg;
        rdata[M0_ERASE]   = erase_fail_flag_reg;
      end
      OFS_LOCKST: rdata[0] = lockst_reg;
      OFS_CTRL:   rdata[1:0] = ctrl_reg;
      OFS_IDRX:   rdata = idrx_reg;
      OFS_IDSTAT: begin
        rdata[IS_MATCH]    = id_match;
        rdata[IS_SERIAL]   = serial_mode;
        rdata[IS_PARALLEL] = parallel_mode;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_req;
      if (acc_req) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= ~mapped;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chk_cnt_reg <= '0;
      chk_reg     <= 1'b0;
    end else if (chk_cnt_reg == '0) begin
      chk_cnt_reg <= DW'(CHECK_DIV - 1);
      chk_reg     <= ~chk_reg;
    end else begin
      chk_cnt_reg <= chk_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      handshake_pin    <= 1'b0;
      handshake_pin_en <= 1'b0;
    end else begin
      handshake_pin_en <= serial_mode;
      handshake_pin    <= serial_mode &
                          (ctrl_reg[CT_SUBMODE] ? chk_reg : ~ready_reg);
    end
  end

  a_clear_both_flags: assert property (
    clr |=> !erase_fail_flag_reg && !program_fail_flag_reg)
    else $error("clear status left a failure flag set");
  a_refuse_on_fail: assert property (
    cmd_wr && first && refused
    |=> st_reg == $past(st_reg) && ready_reg)
    else $error("command accepted while a failure flag was set");
  a_seq_err_flags: assert property (
    cmd_wr && two && code != CMD_READ_ARRAY && code != CMD_CONFIRM
    |=> erase_fail_flag_reg && program_fail_flag_reg && st_reg == ST_STAT)
    else $error("bad second cycle did not flag sequence error");
  a_erase_locked: assert property (
    cmd_wr && st_reg == ST_ERS2 && is_conf && lk.locked
    && !lock_disable_control_reg && !program_fail_flag_reg
    |=> erase_fail_flag_reg && !program_fail_flag_reg && ready_reg)
    else $error("locked erase not reported as erase error");
  a_prog_verify: assert property (
    done && op_reg == OP_PGM && verify_fail && !erase_fail_flag_reg
    |=> program_fail_flag_reg && !erase_fail_flag_reg)
    else $error("failed program not reported as program error");
  a_abort_read: assert property (
    cmd_wr && two && code == CMD_READ_ARRAY
    |=> st_reg == ST_ARRAY && ready_reg && $stable(erase_fail_flag_reg))
    else $error("read array code did not cancel command");
  a_lock_disable: assert property (
    cmd_wr && st_reg == ST_ERS2 && is_conf && lock_disable_control_reg
    |=> st_reg == ST_BUSY && !ready_reg)
    else $error("erase refused although lock disabled");
  a_status_byte: assert property (
    acc_req && !pwrite && paddr == OFS_FCMD && st_reg == ST_STAT
    && !serial_mode |=> pready && prdata[7:0] == $past(status))
    else $error("status byte not on data bits 0-7");
  a_boot_block: assert property (
    parallel_mode && faddr_reg[19:12] == BOOT_LO[19:12]
    |-> cur_blk == BOOT_BLK)
    else $error("boot ROM range not mapped to boot block");
  a_id_gate: assert property (
    wr_acc && paddr == OFS_FCMD && serial_mode && !id_match
    && st_reg != ST_BUSY |=> st_reg == $past(st_reg))
    else $error("command taken with mismatched identification");
  a_busy_pin: assert property (
    serial_mode && !ctrl_reg[CT_SUBMODE] && $stable(serial_mode)
    |=> handshake_pin == !$past(ready_reg) && handshake_pin_en)
    else $error("handshake pin does not show busy");
  a_protect_read: assert property (
    acc_req && !pwrite && paddr == OFS_FCMD && serial_mode
    && ctrl_reg[CT_PROTECT] |=> prdata == 32'h0000_0000)
    else $error("protected flash read returned data");
  a_ready_span: assert property (
    start |=> !ready_reg ##1 (!ready_reg && st_reg == ST_BUSY))
    else $error("ready did not drop during operation");
  a_confirm_addr: assert property (
    cmd_wr && st_reg == ST_ERS2 && !top_ok |=> st_reg != ST_BUSY)
    else $error("erase started off block top address");

  c_erase_ok: cover property (
    start && st_reg == ST_ERS2 ##[1:300] lk.set_unlock);
  c_abort: cover property (cmd_wr && two && code == CMD_READ_ARRAY);
  c_seq_err: cover property (seq_err ##[1:50] clr);
  c_lock_prog: cover property (lk.set_lock);
endmodule

// *** rtl/fes_pkg.sv ***
// Constants and types of the flash error/status sequencer.
// Assumes a 20-bit flash address space in 4 Kbyte erase blocks.
package fes_pkg;
  // APB register offsets (byte addresses)
  localparam logic [7:0] OFS_FCMD   = 8'h00;
  localparam logic [7:0] OFS_FADDR  = 8'h04;
  localparam logic [7:0] OFS_MODE0  = 8'h08;
  localparam logic [7:0] OFS_LOCKST = 8'h0C;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam logic [7:0] OFS_IDRX   = 8'h14;
  localparam logic [7:0] OFS_IDSTAT = 8'h18;

  // Command codes, low byte of a bus cycle
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR       = 8'h50;
  localparam logic [7:0] CMD_PROGRAM     = 8'h40;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_LOCK        = 8'h77;
  localparam logic [7:0] CMD_READ_LOCK   = 8'h71;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;

  // Status byte bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE = 5;
  localparam int SR_PROG  = 4;
  // flash_mode_reg_zero bit positions
  localparam int M0_READY   = 0;
  localparam int M0_LOCKDIS = 2;
  localparam int M0_PROG    = 6;
  localparam int M0_ERASE   = 7;
  // Control register bit positions
  localparam int CT_SUBMODE = 0;
  localparam int CT_PROTECT = 1;
  // Identification status bit positions
  localparam int IS_MATCH    = 0;
  localparam int IS_SERIAL   = 1;
  localparam int IS_PARALLEL = 2;

  // Address map
  localparam int          BLK_SHIFT = 12;
  localparam logic [11:0] BLK_TOP   = 12'hFFE;
  localparam logic [19:0] BOOT_LO   = 20'hFF000;
  localparam logic [19:0] BOOT_HI   = 20'hFFFFF;

  // Values after reset
  localparam logic READY_RST = 1'b1;
  localparam logic FLAG_RST  = 1'b0;
  localparam logic LOCK_RST  = 1'b1;

  typedef enum logic [2:0] {
    ST_ARRAY, ST_STAT, ST_PGM2, ST_ERS2, ST_LCK2, ST_RLK2, ST_BUSY
  } fes_state_e;

  typedef enum logic [1:0] {OP_PGM, OP_ERS, OP_LCK} fes_op_e;
endpackage

// *** rtl/fes_lock_if.sv ***
// Lock-bit table access between sequencer and lock table.
// Assumes both ends share mclk; locked is combinational.
`timescale 1ns/100ps
interface fes_lock_if #(parameter int BW = 4);
  logic [BW-1:0] blk;
  logic          set_unlock;
  logic          set_lock;
  logic          locked;
  modport owner (input blk, input set_unlock, input set_lock,
                 output locked);
  modport user  (output blk, output set_unlock, output set_lock,
                 input locked);
endinterface

// *** rtl/fes_lock_table.sv ***
// Per-block lock bits of the flash array.
// Assumes only one of set_unlock and set_lock per cycle.
`timescale 1ns/100ps
module fes_lock_table
  import fes_pkg::*;
#(
  parameter int NBLK = 9,  // Blocks, boot block last
  parameter int BW   = 4   // Block index width
)(
  input wire logic mclk,  // System clock
  input wire logic rstn,  // Async reset, active low
  fes_lock_if.owner lk    // Lock table access
);
  logic [NBLK-1:0] lock_reg;

  if (NBLK < 2 || NBLK > (1 << BW)) begin : g_chk
    $error("NBLK does not fit the block index");
  end

  for (genvar i = 0; i < NBLK; i++) begin : g_blk
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        lock_reg[i] <= LOCK_RST;
      end else if (lk.blk == BW'(i)) begin
        if (lk.set_unlock) begin
          lock_reg[i] <= 1'b1;
        end else if (lk.set_lock) begin
          lock_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Lock bit zero means protected; out of range reads as free
  assign lk.locked = (32'(lk.blk) < NBLK) ? ~lock_reg[lk.blk] : 1'b0;

  a_lock_set: assert property (@(posedge mclk) disable iff (!rstn)
    lk.set_lock |=> lock_reg[$past(lk.blk)] == 1'b0)
    else $error("lock program did not clear lock bit");
  a_lock_erase: assert property (@(posedge mclk) disable iff (!rstn)
    lk.set_unlock |=> lock_reg[$past(lk.blk)] == 1'b1)
    else $error("erase did not set lock bit");
endmodule

// *** dv/fes_flash_model.sv ***
// Flash array stand-in: read data, identification, verify result.
// Assumes the bench chooses each verify outcome.
`timescale 1ns/100ps
module fes_flash_model #(
  parameter logic [31:0] ID = 32'h1234_5678  // Arbitrary value
)(
  input  wire logic        mclk,      // System clock
  input  wire logic        rstn,      // Device reset, active low
  input  wire logic        submode,   // Serial sub-mode 2 selected
  input  wire logic        fail_req,  // Next verify fails
  output logic      [15:0] rdata,     // Array read data
  output logic             vfail,     // Verify result
  output logic      [31:0] id,        // Stored identification
  output logic             sclk,      // Programmer serial clock
  output logic             txd        // Level on transmit pin
);
  logic sclk_reg;

  // clock in mode 1, low in mode 2
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_reg <= 1'b0;
    end else begin
      sclk_reg <= submode ? 1'b0 : ~sclk_reg;
    end
  end
  assign sclk = sclk_reg;
  assign txd = 1'b1;
  assign vfail = fail_req;
  assign rdata = 16'hA5C3;
  assign id    = ID;
endmodule

// *** dv/tb.sv ***
// Bench for the flash error/status sequencer over APB.
// Assumes short auto operations so waits stay small.
`timescale 1ns/100ps
module tb;
  import fes_pkg::*;
  localparam logic [31:0] ID = 32'h1234_5678;  // Arbitrary value
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        fail_req, bmp, msp, hs, hs_en, vf, hp, sub2;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, fid;
  logic [15:0] frd;
  logic [33:0] expq[$];
  logic [33:0] e;
  int          err_count, n_tests, tg;
  fes_top #(.OP_CYCLES(8), .CHECK_DIV(2)) fes_top_i (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_rdata(frd),
    .verify_fail(vf), .flash_id(fid), .boot_mode_pin(bmp),
    .mode_select_pin(msp), .handshake_pin(hs), .handshake_pin_en(hs_en));
  fes_flash_model #(.ID(ID)) fes_flash_model_i (
    .mclk(mclk), .rstn(rstn), .submode(sub2), .fail_req(fail_req),
    .rdata(frd), .vfail(vf), .id(fid), .sclk(), .txd());
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk) penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 0;
    penable <= 0;
    // Idle cycle so the next call never re-drives psel in one step
    @(posedge mclk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [33:0] x);
    expq.push_back(x);
    xfer(0, a, 0);
  endtask
  task automatic op(logic [7:0] c, logic [19:0] a, logic f, logic [7:0] x);
    fail_req <= f;
    wr(OFS_FADDR, {12'h0, a});
    wr(OFS_FCMD, {24'h0, c});
    wr(OFS_FCMD, (c == CMD_PROGRAM) ? ($urandom & 32'hFFFF) : 32'hD0);
    repeat (10) @(posedge mclk);
    rd(OFS_MODE0, {26'h0, x});
    wr(OFS_FCMD, {24'h0, CMD_CLEAR});
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read answers checked at the pready edge
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) chk(prdata, e[31:0]);
    end
  end
  initial begin
    #(50 * 4000);
    err_count++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, fail_req, bmp, msp, rstn, sub2} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h905f));
    repeat (3) @(posedge mclk);
    rstn <= 1;
    rd(OFS_MODE0, 34'h1);
    rd(OFS_FCMD, 34'hA5C3);
    wr(OFS_FCMD, 32'h30 | ($urandom & 32'h0F));
    rd(OFS_FCMD, 34'hB0);
    wr(OFS_FADDR, 32'h0FFE);
    wr(OFS_FCMD, 32'h20);
    wr(OFS_FCMD, 32'hD0);
    rd(OFS_MODE0, 34'hC1);
    wr(OFS_FCMD, 32'h50);
    rd(OFS_MODE0, 34'h1);
    wr(OFS_FCMD, 32'h20);
    wr(OFS_FCMD, 32'hFF);
    rd(OFS_FCMD, 34'hA5C3);
    op(CMD_ERASE, 20'h00FFE, 0, 8'h01);
    fail_req <= 1;
    wr(OFS_FCMD, 32'h20);
    wr(OFS_FCMD, 32'hD0);
    rd(OFS_MODE0, 34'h0);
    repeat (8) @(posedge mclk);
    rd(OFS_MODE0, 34'h81);
    wr(OFS_FCMD, 32'h50);
    wr(OFS_FCMD, 32'h20);
    wr(OFS_FCMD, 32'h80 | ($urandom & 32'h3F));
    rd(OFS_MODE0, 34'hC1);
    wr(OFS_FCMD, 32'h50);
    op(CMD_PROGRAM, 20'h00100, 1, 8'h41);
    op(CMD_LOCK, 20'h01FFE, 1, 8'h41);
    op(CMD_LOCK, 20'h01FFE, 0, 8'h01);
    op(CMD_ERASE, 20'h01FFE, 0, 8'h81);
    op(CMD_PROGRAM, 20'h01000, 0, 8'h41);
    op(CMD_ERASE, 20'h01000, 0, 8'hC1);
    wr(OFS_MODE0, 32'h4);
    op(CMD_ERASE, 20'h01FFE, 0, 8'h05);
    wr(OFS_MODE0, 32'h0);
    op(CMD_PROGRAM, 20'h01000, 0, 8'h01);
    bmp <= 1;
    msp <= 1;
    op(CMD_ERASE, 20'hFFFFE, 1, 8'h81);
    msp <= 0;
    wr(OFS_IDRX, 32'h0);
    rd(OFS_IDSTAT, 34'h2);
    wr(OFS_FCMD, 32'h33);
    rd(OFS_MODE0, 34'h1);
    wr(OFS_IDRX, ID);
    rd(OFS_IDSTAT, 34'h3);
    chk({30'h0, hs_en, hs}, 32'h2);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_FCMD, 34'h0);
    wr(OFS_FCMD, 32'h33);
    rd(OFS_MODE0, 34'h1);
    wr(OFS_CTRL, 32'h1);
    sub2 <= 1;
    hp = hs;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      tg += (hs !== hp);
      hp = hs;
    end
    chk(tg >= 2, 1);
    // Mid-run reset in serial mode, long enough for mode entry
    sub2 <= 0;
    rstn <= 0;
    repeat (20) @(posedge mclk);
    rstn <= 1;
    rd(OFS_CTRL, 34'h0);
    fail_req <= 0;
    wr(OFS_IDRX, ID);
    wr(OFS_FADDR, 32'h0000_0FFE);
    wr(OFS_FCMD, {24'h0, CMD_ERASE});
    wr(OFS_FCMD, {24'h0, CMD_CONFIRM});
    @(posedge mclk);
    chk({30'h0, hs_en, hs}, 32'h3);
    repeat (8) @(posedge mclk);
    rd(OFS_MODE0, 34'h1);
    rd(8'h1C, 34'h300000000);
    repeat (2) @(posedge mclk);
    print_verdict();
  end
endmodule
